// File: design/ecrm_defs.svh
// register map, field layout and code constants of the event routing matrix
`ifndef ECRM_DEFS_SVH
`define ECRM_DEFS_SVH
// register indices, byte address is four times the index
`define ECRM_IDX_SRC_SEL 12'hF98
`define ECRM_IDX_SRC_DATA 12'hF99
`define ECRM_IDX_DST_SEL 12'hF9A
`define ECRM_IDX_DST_DATA 12'hF9B
`define ECRM_ADDR_SRC_SEL 16'h3E60
`define ECRM_ADDR_SRC_DATA 16'h3E64
`define ECRM_ADDR_DST_SEL 16'h3E68
`define ECRM_ADDR_DST_DATA 16'h3E6C
// field widths and reset values
`define ECRM_SRC_SEL_W 4
`define ECRM_SRC_CODE_W 7
`define ECRM_DST_IDX_W 6
`define ECRM_DST_LINK_W 4
`define ECRM_CONNECT_BIT 3
`define ECRM_RESET_VAL 8'h00
// source codes
`define ECRM_SRC_OFF 7'h00
`define ECRM_SRC_SOFT 7'h01
`define ECRM_SRC_TMR0_A 7'h10
`define ECRM_SRC_TMR0_B 7'h11
`define ECRM_SRC_TMR1_A 7'h14
`define ECRM_SRC_TMR1_B 7'h15
`define ECRM_SRC_TMR2_A 7'h18
`define ECRM_SRC_TMR2_B 7'h19
`define ECRM_SRC_MCT_A 7'h1C
`define ECRM_SRC_MCT_B 7'h1D
`define ECRM_SRC_MCT_C 7'h1E
`define ECRM_SRC_MCT_D 7'h1F
`define ECRM_SRC_RTC_ALARM 7'h2C
`define ECRM_SRC_RTC_PRESC 7'h2D
`define ECRM_SRC_CMP0 7'h40
`define ECRM_SRC_CMP1 7'h41
`define ECRM_SRC_CMP_WIN 7'h42
`define ECRM_SRC_PA_FIRST 7'h50
`define ECRM_SRC_PA_LAST 7'h57
`define ECRM_SRC_PC_FIRST 7'h64
`define ECRM_SRC_PC_LAST 7'h67
`define ECRM_SRC_PE_FIRST 7'h73
`define ECRM_SRC_PE_LAST 7'h76
// destination indices
`define ECRM_DST_ADC 6'h04
`define ECRM_DST_DAC 6'h08
`define ECRM_DST_TMR0_IN0 6'h10
`define ECRM_DST_TMR0_IN1 6'h11
`define ECRM_DST_TMR1_IN0 6'h14
`define ECRM_DST_TMR1_IN1 6'h15
`define ECRM_DST_TMR2_IN0 6'h18
`define ECRM_DST_TMR2_IN1 6'h19
`define ECRM_DST_MCT_A 6'h1C
`define ECRM_DST_MCT_D 6'h1F
`define ECRM_DST_MCT_GEN 6'h20
`define ECRM_DST_RTC 6'h2C
`define ECRM_DST_EVO_FIRST 6'h30
`define ECRM_DST_EVO_LAST 6'h33
`endif

// File: design/ecrm_pkg.sv
// types shared by the event routing matrix
package ecrm_pkg;
  // event sources feeding the channels
  typedef struct packed {
    logic [2:0] timer_out;
    logic [3:0] mct_out;
    logic rtc_alarm;
    logic rtc_prescaled;
    logic [1:0] comparator_out;
    logic comparator_window_detect;
    logic [7:0] port_a_pin;
    logic [3:0] port_c_pin;
    logic [3:0] port_e_pin;
  } ecrm_src_t;
  // destination inputs driven by the matrix
  typedef struct packed {
    logic adc_trigger;
    logic dac_trigger;
    logic [5:0] timer_in;
    logic [3:0] mct_in;
    logic mct_general_in;
    logic rtc_source;
    logic [3:0] event_pin_output;
  } ecrm_dst_t;
  // one destination channel link subregister
  typedef struct packed {
    logic destination_connect_bit;
    logic [2:0] destination_channel_field;
  } ecrm_link_t;
endpackage

// File: design/ecrm_top.sv
// event routing matrix: eight channels, 18 destinations, apb register slave
//
// Functional notes
// - seven-bit channel source code, top reads zero
// - source subaddress 0-7 picks channel subregister
// - code zero drives channel low
// - code one holds channel high
// - timer and multi-channel timer source codes
// - real-time-clock alarm and prescaled clock codes
// - comparator and window detect source codes
// - port A pins as sources
// - port C and port E pins as sources
// - destination subaddress six bits, top zero
// - destination subdata reaches indexed subregister
// - converter trigger destinations
// - timer input destinations
// - multi-channel timer input destinations
// - real-time-clock source destination
// - four general-purpose event outputs
// - destination subdata four bits, top zero
// - connect bit clear ties destination low
// - connect bit set follows selected channel
// - channel field encodes channel number directly
// - all subregisters reset to zero
// - source subaddress register at F98
// - source subdata register at F99
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "ecrm_defs.svh"

module ecrm_top (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire ecrm_pkg::ecrm_src_t src_in,
  output ecrm_pkg::ecrm_dst_t dst_out,
  output logic [7:0] channel_level_out
);

  // ==========================================================
  // decoding functions
  // ==========================================================

  // level of one channel for a given source code
  function automatic logic src_level(
    input logic [6:0] code,
    input ecrm_pkg::ecrm_src_t s
  );
    logic lvl;
    lvl = 1'b0;
    case (code)
      `ECRM_SRC_OFF: lvl = 1'b0;
      `ECRM_SRC_SOFT: lvl = 1'b1;
      `ECRM_SRC_TMR0_A: lvl = s.timer_out[0];
      `ECRM_SRC_TMR0_B: lvl = s.timer_out[0];
      `ECRM_SRC_TMR1_A: lvl = s.timer_out[1];
      `ECRM_SRC_TMR1_B: lvl = s.timer_out[1];
      `ECRM_SRC_TMR2_A: lvl = s.timer_out[2];
      `ECRM_SRC_TMR2_B: lvl = s.timer_out[2];
      `ECRM_SRC_MCT_A: lvl = s.mct_out[0];
      `ECRM_SRC_MCT_B: lvl = s.mct_out[1];
      `ECRM_SRC_MCT_C: lvl = s.mct_out[2];
      `ECRM_SRC_MCT_D: lvl = s.mct_out[3];
      `ECRM_SRC_RTC_ALARM: lvl = s.rtc_alarm;
      `ECRM_SRC_RTC_PRESC: lvl = s.rtc_prescaled;
      `ECRM_SRC_CMP0: lvl = s.comparator_out[0];
      `ECRM_SRC_CMP1: lvl = s.comparator_out[1];
      `ECRM_SRC_CMP_WIN: lvl = s.comparator_window_detect;
      default: begin
        if (code >= `ECRM_SRC_PA_FIRST && code <= `ECRM_SRC_PA_LAST) begin
          lvl = s.port_a_pin[code[2:0]];
        end
        // port C pins 4 to 7
        else if (code >= `ECRM_SRC_PC_FIRST && code <= `ECRM_SRC_PC_LAST) begin
          lvl = s.port_c_pin[code[1:0]];
        end
        // port E pins 3 to 6
        else if (code >= `ECRM_SRC_PE_FIRST && code <= `ECRM_SRC_PE_LAST) begin
          lvl = s.port_e_pin[2'(code - `ECRM_SRC_PE_FIRST)];
        end
        else begin
          lvl = 1'b0;
        end
      end
    endcase
    return lvl;
  endfunction

  // true for destination indices that have a subregister
  function automatic logic dst_valid(input logic [5:0] idx);
    logic ok;
    ok = 1'b0;
    case (idx)
      `ECRM_DST_ADC: ok = 1'b1;
      `ECRM_DST_DAC: ok = 1'b1;
      `ECRM_DST_TMR0_IN0: ok = 1'b1;
      `ECRM_DST_TMR0_IN1: ok = 1'b1;
      `ECRM_DST_TMR1_IN0: ok = 1'b1;
      `ECRM_DST_TMR1_IN1: ok = 1'b1;
      `ECRM_DST_TMR2_IN0: ok = 1'b1;
      `ECRM_DST_TMR2_IN1: ok = 1'b1;
      `ECRM_DST_MCT_GEN: ok = 1'b1;
      `ECRM_DST_RTC: ok = 1'b1;
      default: begin
        if (idx >= `ECRM_DST_MCT_A && idx <= `ECRM_DST_MCT_D) begin
          ok = 1'b1;
        end
        else if (idx >= `ECRM_DST_EVO_FIRST && idx <= `ECRM_DST_EVO_LAST) begin
          ok = 1'b1;
        end
        else begin
          ok = 1'b0;
        end
      end
    endcase
    return ok;
  endfunction

  // ==========================================================
  // register state
  // ==========================================================

  logic [`ECRM_SRC_SEL_W-1:0] source_index_select;
  logic [`ECRM_DST_IDX_W-1:0] destination_index_select;
  logic [`ECRM_SRC_CODE_W-1:0] channel_source_select [0:7];
  ecrm_pkg::ecrm_link_t destination_channel_link [0:63];
  logic [31:0] rdata_q;
  ecrm_pkg::ecrm_dst_t dst_q;
  logic [7:0] chan_q;

  // ==========================================================
  // apb decode
  // ==========================================================

  // decode nets, full address compare
  wire setup_phase;
  wire access_phase;
  wire hit_src_sel;
  wire hit_src_data;
  wire hit_dst_sel;
  wire hit_dst_data;
  wire hit_any;
  wire wr_ok;

  // phase and address decode
  assign setup_phase = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  assign hit_src_sel = (paddr_in == `ECRM_ADDR_SRC_SEL);
  assign hit_src_data = (paddr_in == `ECRM_ADDR_SRC_DATA);
  assign hit_dst_sel = (paddr_in == `ECRM_ADDR_DST_SEL);
  assign hit_dst_data = (paddr_in == `ECRM_ADDR_DST_DATA);
  assign hit_any = hit_src_sel | hit_src_data | hit_dst_sel | hit_dst_data;
  // writes need the low byte lane, the only one holding bits
  assign wr_ok = access_phase & pwrite_in & pstrb_in[0];

  // zero-wait slave, error on unmapped address
  assign pready_out = 1'b1;
  assign pslverr_out = access_phase & ~hit_any;
  assign prdata_out = rdata_q;

  // ==========================================================
  // indirect access pointers
  // ==========================================================

  // pointer and strobe nets
  wire src_ptr_ok;
  wire [2:0] src_ptr;
  wire dst_ptr_ok;
  wire [5:0] dst_ptr;
  wire we_src_sel;
  wire we_src_data;
  wire we_dst_sel;
  wire we_dst_data;

  // channel only when subaddress below eight
  assign src_ptr_ok = ~source_index_select[3];
  assign src_ptr = source_index_select[2:0];
  assign dst_ptr_ok = dst_valid(destination_index_select);
  assign dst_ptr = destination_index_select;

  // write strobes for each target
  assign we_src_sel = wr_ok & hit_src_sel;
  // subaddress 8 to 15 reaches no channel
  assign we_src_data = wr_ok & hit_src_data & src_ptr_ok;
  assign we_dst_sel = wr_ok & hit_dst_sel;
  assign we_dst_data = wr_ok & hit_dst_data & dst_ptr_ok;

  // ==========================================================
  // read data
  // ==========================================================

  // current subregister contents, zero where nothing is mapped
  wire [6:0] src_view;
  wire [3:0] dst_view;
  assign src_view = src_ptr_ok ? channel_source_select[src_ptr] : 7'h00;
  assign dst_view = dst_ptr_ok ? destination_channel_link[dst_ptr] : 4'h0;

  // read mux, upper bits zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_src_sel) begin
      next_rdata = {28'h000_0000, source_index_select};
    end
    else if (hit_src_data) begin
      next_rdata = {25'h000_0000, src_view};
    end
    else if (hit_dst_sel) begin
      next_rdata = {26'h000_0000, destination_index_select};
    end
    else if (hit_dst_data) begin
      next_rdata = {28'h000_0000, dst_view};
    end
    else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // capture read data in setup cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 32'h0000_0000;
    end
    else if (setup_phase & ~pwrite_in) begin
      rdata_q <= next_rdata;
    end
  end

  // ==========================================================
  // subaddress registers
  // ==========================================================

  // pointer registers keep only defined bits
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      source_index_select <= 4'h0;
      destination_index_select <= 6'h00;
    end
    else begin
      if (we_src_sel) begin
        source_index_select <= pwdata_in[3:0];
      end
      if (we_dst_sel) begin
        destination_index_select <= pwdata_in[5:0];
      end
    end
  end

  // ==========================================================
  // channels
  // ==========================================================

  logic [7:0] next_chan;
  genvar gc;
  generate
    for (gc = 0; gc < 8; gc++) begin : g_chan
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          channel_source_select[gc] <= 7'h00;
        end
        // seven-bit code stored
        // pointer compared at channel-number width
        else if (we_src_data && src_ptr == 3'(gc)) begin
          channel_source_select[gc] <= pwdata_in[6:0];
        end
      end
      // channel level from its source code
      assign next_chan[gc] = src_level(channel_source_select[gc], src_in);
    end
  endgenerate

  // registered channel levels
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chan_q <= 8'h00;
    end
    else begin
      chan_q <= next_chan;
    end
  end
  assign channel_level_out = chan_q;

  // ==========================================================
  // destinations
  // ==========================================================

  logic [63:0] dst_level;
  genvar gd;
  generate
    for (gd = 0; gd < 64; gd++) begin : g_dst
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          destination_channel_link[gd] <= 4'h0;
        end
        // write to indexed link
        // pointer compared at index width
        else if (we_dst_data && dst_ptr == 6'(gd)) begin
          destination_channel_link[gd] <= pwdata_in[3:0];
        end
      end
      assign dst_level[gd] =
        destination_channel_link[gd].destination_connect_bit &
        next_chan[destination_channel_link[gd].destination_channel_field];
    end
  endgenerate

  // map destination levels onto named inputs
  ecrm_pkg::ecrm_dst_t next_dst;
  always_comb begin
    next_dst.adc_trigger = dst_level[`ECRM_DST_ADC];
    next_dst.dac_trigger = dst_level[`ECRM_DST_DAC];
    next_dst.timer_in[0] = dst_level[`ECRM_DST_TMR0_IN0];
    next_dst.timer_in[1] = dst_level[`ECRM_DST_TMR0_IN1];
    next_dst.timer_in[2] = dst_level[`ECRM_DST_TMR1_IN0];
    next_dst.timer_in[3] = dst_level[`ECRM_DST_TMR1_IN1];
    next_dst.timer_in[4] = dst_level[`ECRM_DST_TMR2_IN0];
    next_dst.timer_in[5] = dst_level[`ECRM_DST_TMR2_IN1];
    // multi-channel timer inputs A to D
    next_dst.mct_in[0] = dst_level[`ECRM_DST_MCT_A];
    next_dst.mct_in[1] = dst_level[`ECRM_DST_MCT_A + 6'h01];
    next_dst.mct_in[2] = dst_level[`ECRM_DST_MCT_A + 6'h02];
    next_dst.mct_in[3] = dst_level[`ECRM_DST_MCT_D];
    next_dst.mct_general_in = dst_level[`ECRM_DST_MCT_GEN];
    next_dst.rtc_source = dst_level[`ECRM_DST_RTC];
    next_dst.event_pin_output[0] = dst_level[`ECRM_DST_EVO_FIRST];
    next_dst.event_pin_output[1] = dst_level[`ECRM_DST_EVO_FIRST + 6'h01];
    next_dst.event_pin_output[2] = dst_level[`ECRM_DST_EVO_FIRST + 6'h02];
    next_dst.event_pin_output[3] = dst_level[`ECRM_DST_EVO_LAST];
  end

  // registered destination outputs
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dst_q <= '0;
    end
    else begin
      dst_q <= next_dst;
    end
  end
  assign dst_out = dst_q;

endmodule

// File: bench/ecrm_sva.sv
// port-level assertion checker for the event routing matrix
`timescale 1ns/10ps
`include "ecrm_defs.svh"
module ecrm_sva (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire ecrm_pkg::ecrm_src_t src_in,
  input wire ecrm_pkg::ecrm_dst_t dst_out,
  input wire logic [7:0] channel_level_out
);
  // ==========================
  // helper decode
  wire logic acc = psel_in && penable_in;
  wire logic rd_acc = acc && !pwrite_in;
  wire logic mapped = paddr_in inside {`ECRM_ADDR_SRC_SEL, `ECRM_ADDR_SRC_DATA,
    `ECRM_ADDR_DST_SEL, `ECRM_ADDR_DST_DATA};
  logic src_written;
  // remembers any source data write with the low byte lane strobed since reset, at any subaddress
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_written <= 1'b0;
    end else if (acc && pwrite_in && paddr_in == `ECRM_ADDR_SRC_DATA && pstrb_in[0]) begin
      src_written <= 1'b1;
    end
  end
  // ==========================
  // properties
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  idle_low_a: assert property (!src_written |-> channel_level_out == 8'h00)
    else $error("channel active without a source code");
  route_chan_a: assert property ((|dst_out) |-> (|channel_level_out))
    else $error("destination high with every channel low");
  src_rsv_a: assert property (rd_acc && paddr_in == `ECRM_ADDR_SRC_DATA |-> prdata_out[31:7] == 25'h0)
    else $error("source code upper bits not zero");
  dsel_rsv_a: assert property (rd_acc && paddr_in == `ECRM_ADDR_DST_SEL |-> prdata_out[31:6] == 26'h0)
    else $error("destination index upper bits not zero");
  dst_rsv_a: assert property (rd_acc && paddr_in == `ECRM_ADDR_DST_DATA |-> prdata_out[31:4] == 28'h0)
    else $error("destination link upper bits not zero");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr_out)
    else $error("mapped access refused");
  setup_quiet_a: assert property (psel_in && !penable_in |-> !pslverr_out ##1 pready_out)
    else $error("setup cycle error or late ready");
  reset_zero_a: assert property ($rose(rstn_in) |-> dst_out == '0 && channel_level_out == 8'h00)
    else $error("outputs not cleared by reset");
endmodule
bind ecrm_top ecrm_sva i_ecrm_sva (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .src_in(src_in), .dst_out(dst_out),
  .channel_level_out(channel_level_out));

// File: bench/ecrm_src_model.sv
// model of the peripheral event sources feeding the matrix
`timescale 1ns/10ps
module ecrm_src_model (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire ecrm_pkg::ecrm_src_t value_in,
  output ecrm_pkg::ecrm_src_t src_out
);
  // sources change only just after a clock edge, quiet in reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_out <= '0;
    end else begin
      src_out <= value_in;
    end
  end
endmodule

// File: bench/tb_event_channel_routing_matrix.sv
// self-checking testbench of the event routing matrix
`timescale 1ns/10ps
`include "ecrm_defs.svh"
module tb_event_channel_routing_matrix;
  logic clk_sys_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err, vld;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic [7:0] channel_level_out;
  ecrm_pkg::ecrm_src_t src_v, src_w;
  ecrm_pkg::ecrm_dst_t dst_out;
  int bad_count, checked, cyc, ch;
  ecrm_top i_ecrm_top (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .src_in(src_w), .dst_out(dst_out),
    .channel_level_out(channel_level_out));
  ecrm_src_model i_ecrm_src_model (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .value_in(src_v), .src_out(src_w));
  // ==========================
  // expectation functions
  function automatic logic exp_src(input logic [6:0] c, input ecrm_pkg::ecrm_src_t s);
    logic r;
    r = (c == 7'h01);
    if (c inside {[7'h10:7'h19]} && !c[1]) r = s.timer_out[c[3:2]];
    if (c inside {[7'h1C:7'h1F]}) r = s.mct_out[c[1:0]];
    if (c == 7'h2C) r = s.rtc_alarm;
    if (c == 7'h2D) r = s.rtc_prescaled;
    if (c inside {7'h40, 7'h41}) r = s.comparator_out[c[0]];
    if (c == 7'h42) r = s.comparator_window_detect;
    if (c inside {[7'h50:7'h57]}) r = s.port_a_pin[c[2:0]];
    if (c inside {[7'h64:7'h67]}) r = s.port_c_pin[c[1:0]];
    if (c inside {[7'h73:7'h76]}) r = s.port_e_pin[c[2:0] - 3'h3];
    return r;
  endfunction
  function automatic ecrm_pkg::ecrm_dst_t exp_dst(input logic [5:0] i, input logic v);
    ecrm_pkg::ecrm_dst_t d;
    d = '0;
    if (i == 6'h04) d.adc_trigger = v;
    if (i == 6'h08) d.dac_trigger = v;
    if (i inside {[6'h10:6'h19]} && !i[1]) d.timer_in[{i[3:2], i[0]}] = v;
    if (i inside {[6'h1C:6'h1F]}) d.mct_in[i[1:0]] = v;
    if (i == 6'h20) d.mct_general_in = v;
    if (i == 6'h2C) d.rtc_source = v;
    if (i inside {[6'h30:6'h33]}) d.event_pin_output[i[1:0]] = v;
    return d;
  endfunction
  // ==========================
  // bus, compare and closing tasks
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    r = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================
  // clock and hang guard
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================
  // main sequence
  initial begin
    {rstn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    pstrb_in = 4'hF; src_v = '0; bad_count = 0; checked = 0; cyc = 0;
    void'($urandom(48046));
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, `ECRM_ADDR_SRC_SEL + 16'(4 * a), 32'h0, rd);
      check(rd, 32'h0);
    end
    // every source code on a rotating channel, random then inverted sources
    for (int c = 0; c < 128; c++) begin
      apb(1'b1, `ECRM_ADDR_SRC_SEL, 32'(c & 7), rd);
      apb(1'b1, `ECRM_ADDR_SRC_DATA, ($urandom & 32'hFFFF_FF80) | 32'(c), rd);
      apb(1'b0, `ECRM_ADDR_SRC_DATA, 32'h0, rd);
      check(rd, 32'(c));
      for (int k = 0; k < 2; k++) begin
        @(posedge clk_sys_in);
        src_v <= k ? ~src_v : $bits(ecrm_pkg::ecrm_src_t)'($urandom);
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check(32'(channel_level_out[c & 7]), 32'(exp_src(7'(c), src_w)));
      end
    end
    // odd channels held high by software, even ones disabled
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `ECRM_ADDR_SRC_SEL, 32'(c), rd);
      apb(1'b1, `ECRM_ADDR_SRC_DATA, 32'(c & 1), rd);
    end
    // every destination index linked, read back, then disconnected
    for (int i = 0; i < 64; i++) begin
      ch = $urandom_range(7, 0);
      apb(1'b1, `ECRM_ADDR_DST_SEL, ($urandom & 32'hC0) | 32'(i), rd);
      apb(1'b0, `ECRM_ADDR_DST_SEL, 32'h0, rd);
      check(rd, 32'(i));
      apb(1'b1, `ECRM_ADDR_DST_DATA, ($urandom & 32'hFFFF_FFF0) | 32'h8 | 32'(ch), rd);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check(32'(dst_out), 32'(exp_dst(6'(i), ch[0])));
      vld = (exp_dst(6'(i), 1'b1) != '0);
      apb(1'b0, `ECRM_ADDR_DST_DATA, 32'h0, rd);
      check(rd, vld ? 32'h8 | 32'(ch) : 32'h0);
      apb(1'b1, `ECRM_ADDR_DST_DATA, 32'h1 | 32'(ch), rd);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check(32'(dst_out), 32'h0);
    end
    // refused accesses
    apb(1'b1, 16'h3E70, 32'hFF, rd);
    check(32'(err), 32'h1);
    apb(1'b1, `ECRM_ADDR_SRC_SEL, 32'h9, rd);
    apb(1'b1, `ECRM_ADDR_SRC_DATA, 32'h10, rd);
    apb(1'b0, `ECRM_ADDR_SRC_DATA, 32'h0, rd);
    check(rd, 32'h0);
    apb(1'b1, `ECRM_ADDR_SRC_SEL, 32'h7, rd);
    pstrb_in <= 4'hE;
    apb(1'b1, `ECRM_ADDR_SRC_DATA, 32'h2C, rd);
    pstrb_in <= 4'hF;
    apb(1'b0, `ECRM_ADDR_SRC_DATA, 32'h0, rd);
    check(rd, 32'h1);
    // reset in mid-run clears every route
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    check(32'(dst_out), 32'h0);
    check(32'(channel_level_out), 32'h0);
    apb(1'b0, `ECRM_ADDR_SRC_DATA, 32'h0, rd);
    check(rd, 32'h0);
    check(32'(channel_level_out), 32'h0);
    give_verdict();
  end
endmodule
